// ==== rtl/event_channel_config.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module event_channel_config
  import event_channel_pkg::*;
#(
  parameter int NUM_CH = NUM_CHANNELS,
  parameter int NUM_GEN = NUM_SOURCES
) (
  input wire logic clk,
  input wire logic rst,
  event_channel_if.dev cfg,
  input wire logic [NUM_GEN-1:0] gen_in,
  output logic [NUM_CH-1:0] event_out
);

  if (NUM_CH < 1 || NUM_CH > 16) begin : g_bad_ch
    $error("channel count must be 1 to 16");
  end
  if (NUM_GEN < 1 || NUM_GEN > 128) begin : g_bad_gen
    $error("generator count must be 1 to 128");
  end

  ////////////////////////////////////////////////////////////////////////
  logic wr_sel;
  logic wr_full;
  logic wr_soft;
  logic [CH_W-1:0] wr_ch;
  logic [CH_W-1:0] ptr_reg;
  logic [1:0] edge_reg [NUM_CH];
  logic [1:0] path_reg [NUM_CH];
  logic [SRC_W-1:0] src_reg [NUM_CH];
  logic [NUM_CH-1:0] sel_lvl;
  logic [NUM_CH-1:0] sync_prev_reg;
  logic [NUM_CH-1:0] rs1_reg;
  logic [NUM_CH-1:0] rs2_reg;
  logic [NUM_CH-1:0] rs3_reg;
  logic [NUM_CH-1:0] cur_lvl;
  logic [NUM_CH-1:0] prev_lvl;
  logic [NUM_CH-1:0] soft_hit;
  logic [NUM_CH-1:0] event_next;
  logic [NUM_CH-1:0] event_reg;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] rdata_reg;
  logic ack_reg;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic edge_hit(
    input logic [1:0] sel,
    input logic cur,
    input logic prv
  );
    case (sel)
      EDGE_NO_OUTPUT: edge_hit = 1'b0;
      EDGE_RISING: edge_hit = cur & ~prv;
      EDGE_FALLING: edge_hit = ~cur & prv;
      EDGE_BOTH: edge_hit = cur ^ prv;
      default: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  function automatic logic path_event(
    input logic [1:0] path,
    input logic [1:0] sel,
    input logic cur,
    input logic prv,
    input logic lvl
  );
    case (path)
      PATH_SYNC: path_event = edge_hit(sel, cur, prv);
      PATH_RESYNC: path_event = edge_hit(sel, cur, prv);
      // level passes unchanged; edge select is expected to be zero
      PATH_ASYNC: path_event = lvl;
      default: path_event = 1'b0;
    endcase
  endfunction : path_event

  ////////////////////////////////////////////////////////////////////////
  // request decode
  assign wr_ch = cfg.wdata[CH_LSB +: CH_W];
  assign wr_sel = cfg.wr & cfg.be[0];
  assign wr_full = cfg.wr & (cfg.be == BE_WORD);
  // soft trigger needs both low byte lanes of the write
  assign wr_soft = wr_sel & cfg.be[1] & cfg.wdata[SOFT_BIT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_reg <= CH_RESET;
    end else if (wr_sel) begin
      ptr_reg <= wr_ch;
    end
  end

  // reserved bits of the write are dropped; out-of-range channels ignored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        edge_reg[i] <= EDGE_RESET;
        path_reg[i] <= PATH_RESET;
        src_reg[i] <= SRC_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wr_full && wr_ch == CH_W'(i)) begin
          edge_reg[i] <= cfg.wdata[EDGE_LSB +: 2];
          path_reg[i] <= cfg.wdata[PATH_LSB +: 2];
          src_reg[i] <= cfg.wdata[SRC_LSB +: SRC_W];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-channel source mux and edge detection
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    assign sel_lvl[g] = source_ok(src_reg[g], NUM_GEN) ?
                        gen_in[src_reg[g]] : 1'b0;
    assign cur_lvl[g] = (path_reg[g] == PATH_RESYNC) ?
                        rs2_reg[g] : sel_lvl[g];
    assign prev_lvl[g] = (path_reg[g] == PATH_RESYNC) ?
                         rs3_reg[g] : sync_prev_reg[g];
    assign soft_hit[g] = wr_soft && (wr_ch == CH_W'(g));
    assign event_next[g] = soft_hit[g] |
                           path_event(path_reg[g], edge_reg[g],
                                      cur_lvl[g], prev_lvl[g],
                                      sel_lvl[g]);
  end

  // resync path: two stages before the edge detector looks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_prev_reg <= '0;
      rs1_reg <= '0;
      rs2_reg <= '0;
      rs3_reg <= '0;
    end else begin
      sync_prev_reg <= sel_lvl;
      rs1_reg <= sel_lvl;
      rs2_reg <= rs1_reg;
      rs3_reg <= rs2_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      event_reg <= '0;
    end else begin
      event_reg <= event_next;
    end
  end

  assign event_out = event_reg;

  ////////////////////////////////////////////////////////////////////////
  // readback of the selected channel
  always_comb begin
    rd_word = WORD_RESET;
    rd_word[CH_LSB +: CH_W] = ptr_reg;
    if (int'(ptr_reg) < NUM_CH) begin
      rd_word[EDGE_LSB +: 2] = edge_reg[ptr_reg];
      rd_word[PATH_LSB +: 2] = path_reg[ptr_reg];
      rd_word[SRC_LSB +: SRC_W] = src_reg[ptr_reg];
    end
  end

  // readback word holds until the next read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= WORD_RESET;
    end else if (cfg.rd) begin
      rdata_reg <= rd_word;
    end
  end

  // every request is answered next cycle, refused ones too
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= cfg.wr | cfg.rd;
    end
  end

  assign cfg.rdata = rdata_reg;
  assign cfg.ack = ack_reg;

endmodule : event_channel_config
`default_nettype wire

// ==== pkg/event_channel_pkg.sv ====
`default_nettype none
package event_channel_pkg;
  localparam int NUM_CHANNELS = 12;
  localparam int NUM_SOURCES = 77;
  localparam int CH_W = 4;
  localparam int SRC_W = 7;
  localparam int DATA_W = 32;
  // field positions of the channel configuration word
  localparam int EDGE_LSB = 26;
  localparam int PATH_LSB = 24;
  localparam int SRC_LSB = 16;
  localparam int SOFT_BIT = 8;
  localparam int CH_LSB = 0;
  localparam logic [3:0] BE_WORD = 4'hF;
  localparam logic [3:0] BE_NONE = 4'h0;
  // edge_select codes
  localparam logic [1:0] EDGE_NO_OUTPUT = 2'h0;
  localparam logic [1:0] EDGE_RISING = 2'h1;
  localparam logic [1:0] EDGE_FALLING = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // path codes
  localparam logic [1:0] PATH_SYNC = 2'h0;
  localparam logic [1:0] PATH_RESYNC = 2'h1;
  localparam logic [1:0] PATH_ASYNC = 2'h2;
  // source_select codes
  localparam logic [6:0] SRC_NONE = 7'h00;
  localparam logic [6:0] SRC_RSV_A = 7'h1C;
  localparam logic [6:0] SRC_RSV_B = 7'h1D;
  localparam logic [6:0] SRC_LAST = 7'h4C;
  // reset values
  localparam logic [3:0] CH_RESET = 4'h0;
  localparam logic [1:0] EDGE_RESET = 2'h0;
  localparam logic [1:0] PATH_RESET = 2'h0;
  localparam logic [6:0] SRC_RESET = 7'h00;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  // controller register map (byte addresses)
  localparam int HOST_ADDR_W = 12;
  localparam logic [11:0] HOST_DATA_OFF = 12'h000;
  localparam logic [11:0] HOST_CMD_OFF = 12'h004;
  localparam logic [11:0] HOST_STATUS_OFF = 12'h008;
  localparam logic [11:0] HOST_RDATA_OFF = 12'h00C;
  localparam int CMD_BE_LSB = 0;
  localparam int CMD_WRITE_BIT = 4;
  localparam int CMD_READ_BIT = 5;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  function automatic logic source_ok(input logic [6:0] code, input int ngen);
    source_ok = (code != SRC_NONE) && (code != SRC_RSV_A) &&
                (code != SRC_RSV_B) && (code <= SRC_LAST) &&
                (int'(code) < ngen);
  endfunction : source_ok
endpackage : event_channel_pkg
`default_nettype wire

// ==== pkg/event_channel_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface event_channel_if;
  logic wr;
  logic rd;
  logic [3:0] be;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ack;
  modport dev (
    input wr,
    input rd,
    input be,
    input wdata,
    output rdata,
    output ack
  );
  modport host (
    output wr,
    output rd,
    output be,
    output wdata,
    input rdata,
    input ack
  );
endinterface : event_channel_if
`default_nettype wire

// ==== rtl/event_channel_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module event_channel_host
  import event_channel_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [HOST_ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  event_channel_if.host cfg
);

  typedef enum logic [0:0] {ST_IDLE, ST_WAIT} host_state_t;

  host_state_t state_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] data_reg;
  logic [DATA_W-1:0] rdata_cap_reg;
  logic [3:0] be_reg;
  logic wr_reg;
  logic rd_reg;
  logic done_reg;
  logic op_read_reg;
  logic access;
  logic commit;
  logic mapped;
  logic cmd_write;
  logic start_wr;
  logic start_rd;
  logic [DATA_W-1:0] rd_val;

  ////////////////////////////////////////////////////////////////////////
  // apb slave with one wait state
  assign access = psel & penable & ~pready_reg;
  assign commit = psel & penable & pready_reg;
  assign mapped = (paddr == HOST_DATA_OFF) || (paddr == HOST_CMD_OFF) ||
                  (paddr == HOST_STATUS_OFF) || (paddr == HOST_RDATA_OFF);
  assign cmd_write = commit & pwrite & (paddr == HOST_CMD_OFF) &
                     (state_reg == ST_IDLE);
  // the write order has priority over the read order
  assign start_wr = cmd_write & pwdata[CMD_WRITE_BIT];
  assign start_rd = cmd_write & ~pwdata[CMD_WRITE_BIT] &
                    pwdata[CMD_READ_BIT];

  always_comb begin
    rd_val = WORD_RESET;
    case (paddr)
      HOST_DATA_OFF: rd_val = data_reg;
      HOST_CMD_OFF: rd_val[CMD_BE_LSB +: 4] = be_reg;
      HOST_STATUS_OFF: begin
        rd_val[STAT_BUSY_BIT] = (state_reg != ST_IDLE);
        rd_val[STAT_DONE_BIT] = done_reg;
      end
      HOST_RDATA_OFF: rd_val = rdata_cap_reg;
      default: rd_val = WORD_RESET;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= WORD_RESET;
    end else begin
      pready_reg <= access;
      pslverr_reg <= access & ~mapped;
      prdata_reg <= (access && !pwrite) ? rd_val : WORD_RESET;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_reg <= WORD_RESET;
    end else if (commit && pwrite && paddr == HOST_DATA_OFF) begin
      data_reg <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one request to the channel block at a time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      be_reg <= BE_NONE;
      op_read_reg <= 1'b0;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else begin
      wr_reg <= start_wr;
      rd_reg <= start_rd;
      case (state_reg)
        ST_IDLE: begin
          if (start_wr || start_rd) begin
            be_reg <= pwdata[CMD_BE_LSB +: 4];
            op_read_reg <= start_rd;
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (cfg.ack) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_reg <= 1'b0;
      rdata_cap_reg <= WORD_RESET;
    end else begin
      if (state_reg == ST_WAIT && cfg.ack) begin
        done_reg <= 1'b1;
        if (op_read_reg) begin
          rdata_cap_reg <= cfg.rdata;
        end
      end else if (start_wr || start_rd) begin
        done_reg <= 1'b0;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign cfg.wr = wr_reg;
  assign cfg.rd = rd_reg;
  assign cfg.be = be_reg;
  // software keeps reserved bits zero and edge zero on async paths
  assign cfg.wdata = data_reg;

endmodule : event_channel_host
`default_nettype wire

// ==== test/event_channel_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module event_channel_asserts #(
  parameter int NUM_CH = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr,
  input wire logic rd,
  input wire logic [3:0] be,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic ack
);
  logic [3:0] ptr_reg;
  logic [3:0] ch_reg;
  logic [31:0] cfg_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_reg <= 4'h0;
    end else if (wr && be[0]) begin
      ptr_reg <= wdata[3:0];
    end
  end
  // last full configure seen on the link
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ch_reg <= 4'h0;
      cfg_reg <= 32'h0;
    end else if (wr && be == 4'hF) begin
      ch_reg <= wdata[3:0];
      cfg_reg <= wdata;
    end
  end
  property p_ack_after;
    (wr || rd) |=> ack;
  endproperty
  a_ack_after: assert property (p_ack_after)
    else $error("no answer one cycle after request");
  property p_ack_cause;
    ack |-> $past(wr || rd) ##1 !ack;
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("answer without request or too long");
  property p_rsv_zero;
    rd |=> (rdata & 32'hF080FFF0) == 32'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved readback bits not zero");
  property p_ptr_read;
    rd |=> rdata[3:0] == ptr_reg;
  endproperty
  a_ptr_read: assert property (p_ptr_read)
    else $error("readback channel differs from pointer");
  property p_cfg_read;
    rd && ptr_reg == ch_reg && int'(ch_reg) < NUM_CH |=>
      (rdata & 32'h0F7F0000) == (cfg_reg & 32'h0F7F0000);
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("readback fields differ from last configure");
  property p_be_hold;
    (wr || rd) |=> $stable(be) [*2];
  endproperty
  a_be_hold: assert property (p_be_hold)
    else $error("byte enables moved after request");
  property p_req_gap;
    (wr || rd) |=> !(wr || rd) [*2];
  endproperty
  a_req_gap: assert property (p_req_gap)
    else $error("request issued before answer");
  property p_rdata_hold;
    !rd |=> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("readback word changed without read");
endmodule : event_channel_asserts
`default_nettype wire

// ==== test/event_channel_config_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module event_channel_config_bench;
  import event_channel_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [76:0] gen_in;
  logic [11:0] event_out;
  logic [31:0] rng = 32'h36;
  logic [11:0] exp_q[$];
  int error_cnt = 0;
  int total_checks = 0;
  event_channel_if link ();
  event_channel_host event_channel_host_inst (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg(link.host));
  event_channel_config #(.NUM_CH(12), .NUM_GEN(77))
    event_channel_config_inst (.clk(clk), .rst(rst), .cfg(link.dev),
    .gen_in(gen_in), .event_out(event_out));
  event_channel_asserts #(.NUM_CH(12)) event_channel_asserts_inst (
    .clk(clk), .rst(rst), .wr(link.wr), .rd(link.rd), .be(link.be),
    .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, x);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    // the answer stands for one cycle only
    check({31'h0, pready}, 32'h0);
  endtask : apb
  task automatic run(input logic [3:0] b, input logic [31:0] d,
                     input logic r);
    logic e;
    apb(1'b1, HOST_DATA_OFF, d, e);
    apb(1'b1, HOST_CMD_OFF, {26'h0, r, ~r, b}, e);
    do begin
      apb(1'b0, HOST_STATUS_OFF, 32'h0, e);
    end while (q[STAT_DONE_BIT] !== 1'b1);
  endtask : run
  // one high phase of a generator, noting the events it must give
  task automatic pulse(input int s, input logic [1:0] e,
                       input logic [1:0] p, input int c);
    logic ok;
    ok = s != 0 && s != 28 && s != 29 && s <= 76;
    if (ok && p < 2 && e[0]) exp_q.push_back(12'h1 << c);
    // level path: one note per cycle the level is seen high
    if (ok && p == 2) repeat (4) exp_q.push_back(12'h1 << c);
    gen_in[s] <= 1'b1;
    repeat (4) @(posedge clk);
    if (ok && p < 2 && e[1]) exp_q.push_back(12'h1 << c);
    gen_in[s] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : pulse
  always @(negedge clk) begin
    if (!rst && event_out !== 12'h0) begin
      if (exp_q.size() == 0) check({20'h0, event_out}, 32'h0);
      else check({20'h0, event_out}, {20'h0, exp_q.pop_front()});
    end
  end
  initial begin
    #2000000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    logic e;
    logic [1:0] ed, pa;
    int s, c;
    logic [31:0] w;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    gen_in = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 12'h010, 32'h0, e);
    check({31'h0, e}, 32'h1);
    for (int i = 0; i < 30; i++) begin
      s = i < 12 ? i : (i < 14 ? i + 16 : 1 + rnd() % 76);
      if (i >= 14 && (s == 28 || s == 29)) s = 30;
      ed = i < 14 ? EDGE_RISING : i[1:0];
      pa = i < 14 ? PATH_SYNC : i[3:2];
      if (pa == PATH_ASYNC) ed = EDGE_NO_OUTPUT;
      c = rnd() % 12;
      w = {4'h0, ed, pa, 1'b0, 7'(s), 12'h0, 4'(c)};
      run(BE_WORD, w | (rnd() & 32'h0080FEF0), 1'b0);
      run(4'h1, 32'(c), 1'b0);
      run(BE_NONE, 32'h0, 1'b1);
      apb(1'b0, HOST_RDATA_OFF, 32'h0, e);
      check(q, w);
      pulse(s, ed, pa, c);
      exp_q.push_back(12'h1 << c);
      run(4'h3, 32'h100 | c, 1'b0);
      run(BE_WORD, 32'(c), 1'b0);
    end
    repeat (10) @(posedge clk);
    check(exp_q.size(), 32'h0);
    report_and_stop();
  end
endmodule : event_channel_config_bench
`default_nettype wire
